/* File: hdl/hbl_pkg.sv */
/*
  Constants and carrier types for the host byte-lane and channel banking block.
  Assumes a single 20 MHz clock domain and a synchronous, active-low reset.
*/
package hbl_pkg;

  // ------------------------------------------------------------
  // Map selection and address conversion
  // ------------------------------------------------------------
  localparam logic HBL_STRAP_SWAPPED_STYLE = 1'b0;  // Strap low selects this map
  localparam logic HBL_STRAP_LINEAR_STYLE = 1'b1;   // Strap high selects the other map
  localparam logic [7:0] HBL_SWAP_XOR_LOW = 8'h03;  // Conversion below the upper quarter
  localparam logic [7:0] HBL_SWAP_XOR_HIGH = 8'h02; // Conversion in the upper quarter

  // ------------------------------------------------------------
  // Register offsets, canonical (strap high) map
  // ------------------------------------------------------------
  localparam logic [7:0] HBL_FIRMWARE_REVISION_OFS = 8'h82;
  localparam logic [7:0] HBL_CHANNEL_SELECT_OFS = 8'hEC;
  localparam logic [7:0] HBL_CHANNEL_MODE_OFS = 8'h18;     // Per-channel mode register
  localparam logic [7:0] HBL_DUAL_BASE_OFS = 8'h1C;        // First of four dual-use offsets
  localparam logic [7:0] HBL_PER_UPPER_LO_OFS = 8'hC0;     // Per-channel window in upper area
  localparam logic [7:0] HBL_PER_UPPER_HI_OFS = 8'hDF;
  localparam logic [7:0] HBL_GLOBAL_LOW_OFS = 8'h80;       // Lower area below this is per-channel

  // ------------------------------------------------------------
  // Field positions and reset values
  // ------------------------------------------------------------
  localparam int HBL_MODE_SYNC_BIT = 7;                        // Mode bit: 1 = synchronous
  localparam logic [7:0] HBL_FIRMWARE_REVISION_RST = 8'h00;    // Arbitrary value
  localparam logic [7:0] HBL_CHANNEL_SELECT_RST = 8'h00;
  localparam int HBL_CHANNELS = 4;
  localparam int HBL_LANES = 2;

  // ------------------------------------------------------------
  // Carrier types
  // ------------------------------------------------------------
  typedef struct packed {
    logic [7:0] addr;   // Byte address on the bus
    logic word;         // 1 = 16-bit access, 0 = single byte
    logic write;        // 1 = write, 0 = read
    logic [15:0] wdata; // Write data, both lanes
  } hbl_req_type;

  typedef struct packed {
    logic valid;        // Device-supplied channel in force
    logic [1:0] chan;   // Channel from interrupt or DMA context
  } hbl_ctx_type;

endpackage

/* File: hdl/hbl_bank.sv */
/*
  Host register access: byte-lane steering, map decode and channel banking.
  Assumes the host holds its request steady while chip select is low and
  releases chip select after acknowledge; one clock, synchronous reset.
*/
`timescale 1ns/1ps
`default_nettype none
// Overview of operation
// - Strap high puts low lane first in byte strings; low puts high lane first.
// - Single bytes: strap high, A0 low uses low lane; strap low reverses.
// - Strap affects data placement and the address map; handshake timing is identical either way.
// - Strap zero selects the swapped-address map, strap one the linear map.
// - One global register set, reachable whatever channel is selected.
// - Four per-channel banks; per-channel offsets reach only the active channel.
// - Written channel number holds until the host writes another value.
// - Interrupt or DMA context supplies the channel number without host writes.
// - Some per-channel offsets decode differently in async and sync mode.
module hbl_bank (
  input wire logic CLOCK_I,                    // 20 MHz clock
  input wire logic RST_N_I,                    // Synchronous reset, active low
  input wire logic LANE_ORDER_STRAP_I,         // Lane order and map strap
  input wire logic CS_N_I,                     // Chip select, active low
  input wire hbl_pkg::hbl_req_type REQ_I,      // Request held during select
  input wire hbl_pkg::hbl_ctx_type CTX_I,      // Interrupt or DMA channel context
  output logic [15:0] DATA_O,                  // Read data, both lanes
  output logic DATA_OE_O,                      // Drives data bus on reads
  output logic ACK_O                           // Acknowledge, held until deselect
);
  import hbl_pkg::*;

  // ------------------------------------------------------------
  // Storage
  // ------------------------------------------------------------
  logic [7:0] bank [HBL_CHANNELS][256];       // Per-channel registers, async view
  logic [7:0] sync_bank [HBL_CHANNELS][4];    // Sync view of dual-use offsets
  logic [7:0] firmware_revision_register;
  logic [7:0] channel_select_register;
  logic done;

  // ------------------------------------------------------------
  // Handshake
  // ------------------------------------------------------------
  wire take = !CS_N_I && !done;
  wire [1:0] active_chan = CTX_I.valid ? CTX_I.chan : channel_select_register[1:0];
  wire chan_from_ctx = CTX_I.valid;
  wire chan_sync = bank[active_chan][HBL_CHANNEL_MODE_OFS][HBL_MODE_SYNC_BIT];

  // ------------------------------------------------------------
  // Per-lane decode
  // ------------------------------------------------------------
  logic [7:0] canon [HBL_LANES];
  logic [7:0] rd_byte [HBL_LANES];
  logic lane_en [HBL_LANES];
  logic is_fw [HBL_LANES];
  logic is_cs [HBL_LANES];
  logic is_per [HBL_LANES];
  logic is_dual [HBL_LANES];

  for (genvar l = 0; l < HBL_LANES; l++) begin : g_lane
    wire a0 = (l == 1) ^ !LANE_ORDER_STRAP_I;
    wire [7:0] bus_addr = {REQ_I.addr[7:1], a0};
    // map conversion by strap
    // Swapped map flips the low address bits, one bit less in the upper quarter
    wire [7:0] swap_xor = (bus_addr[7:6] == 2'b11) ? HBL_SWAP_XOR_HIGH : HBL_SWAP_XOR_LOW;
    assign canon[l] = (LANE_ORDER_STRAP_I == HBL_STRAP_SWAPPED_STYLE) ? (bus_addr ^ swap_xor) : bus_addr;
    assign lane_en[l] = REQ_I.word || (REQ_I.addr[0] == a0);
    assign is_fw[l] = (canon[l] == HBL_FIRMWARE_REVISION_OFS);
    assign is_cs[l] = (canon[l] == HBL_CHANNEL_SELECT_OFS);
    assign is_per[l] = (canon[l] < HBL_GLOBAL_LOW_OFS) ||
                       ((canon[l] >= HBL_PER_UPPER_LO_OFS) && (canon[l] <= HBL_PER_UPPER_HI_OFS));
    assign is_dual[l] = (canon[l][7:2] == HBL_DUAL_BASE_OFS[7:2]) && chan_sync;
    assign rd_byte[l] = !lane_en[l] ? 8'h00 :
                        is_fw[l] ? firmware_revision_register :
                        is_cs[l] ? channel_select_register :
                        is_dual[l] ? sync_bank[active_chan][canon[l][1:0]] :
                        is_per[l] ? bank[active_chan][canon[l]] : 8'h00;
  end

  // ------------------------------------------------------------
  // Handshake and read data
  // ------------------------------------------------------------
  // strap-independent handshake
  always_ff @(posedge CLOCK_I) begin
    if (!RST_N_I) begin
      done <= 1'b0;
      DATA_OE_O <= 1'b0;
      DATA_O <= 16'h0000;
    end else begin
      done <= !CS_N_I && (done || take);
      DATA_OE_O <= !CS_N_I && (take ? !REQ_I.write : DATA_OE_O);
      if (take && !REQ_I.write) begin
        DATA_O <= {rd_byte[1], rd_byte[0]};
      end
    end
  end
  assign ACK_O = done;

  // ------------------------------------------------------------
  // Global registers
  // ------------------------------------------------------------
  // channel select held and read back
  always_ff @(posedge CLOCK_I) begin
    if (!RST_N_I) begin
      firmware_revision_register <= HBL_FIRMWARE_REVISION_RST;
      channel_select_register <= HBL_CHANNEL_SELECT_RST;
    end else begin
      for (int l = 0; l < HBL_LANES; l++) begin
        if (take && REQ_I.write && lane_en[l] && is_fw[l]) begin
          firmware_revision_register <= REQ_I.wdata[8*l +: 8];
        end
        if (take && REQ_I.write && lane_en[l] && is_cs[l]) begin
          channel_select_register <= REQ_I.wdata[8*l +: 8];
        end
      end
    end
  end

  // ------------------------------------------------------------
  // Per-channel banks
  // ------------------------------------------------------------
  // writes reach active bank only
  always_ff @(posedge CLOCK_I) begin
    for (int l = 0; l < HBL_LANES; l++) begin
      if (take && REQ_I.write && lane_en[l] && is_dual[l]) begin
        sync_bank[active_chan][canon[l][1:0]] <= REQ_I.wdata[8*l +: 8];
      end else if (take && REQ_I.write && lane_en[l] && is_per[l]) begin
        bank[active_chan][canon[l]] <= REQ_I.wdata[8*l +: 8];
      end
    end
  end

  // ------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------
  // Helper: write to channel select taken this cycle
  logic cs_wr;
  assign cs_wr = take && REQ_I.write && ((lane_en[0] && is_cs[0]) || (lane_en[1] && is_cs[1]));

  ack_after_take_a: assert property (@(posedge CLOCK_I) disable iff (!RST_N_I)
    take |=> ACK_O) else $error("ack not one cycle after request");
  ack_holds_a: assert property (@(posedge CLOCK_I) disable iff (!RST_N_I)
    ACK_O && !CS_N_I |=> ACK_O) else $error("ack dropped while selected");
  ack_release_a: assert property (@(posedge CLOCK_I) disable iff (!RST_N_I)
    CS_N_I |=> !ACK_O) else $error("ack stayed after deselect");
  chan_hold_a: assert property (@(posedge CLOCK_I) disable iff (!RST_N_I)
    !cs_wr |=> $stable(channel_select_register)) else $error("channel select changed without write");
  chan_readback_a: assert property (@(posedge CLOCK_I) disable iff (!RST_N_I)
    take && !REQ_I.write && !REQ_I.word && LANE_ORDER_STRAP_I && REQ_I.addr == HBL_CHANNEL_SELECT_OFS
    |=> DATA_O[7:0] == channel_select_register && DATA_OE_O) else $error("channel select readback wrong");
  ctx_chan_a: assert property (@(posedge CLOCK_I) disable iff (!RST_N_I)
    chan_from_ctx |-> active_chan == CTX_I.chan) else $error("context channel not used");
  lane_byte_a: assert property (@(posedge CLOCK_I) disable iff (!RST_N_I)
    take && !REQ_I.write && !REQ_I.word && (REQ_I.addr[0] == !LANE_ORDER_STRAP_I)
    |=> DATA_O[15:8] == 8'h00) else $error("byte on wrong lane");
  lane_order_a: assert property (@(posedge CLOCK_I) disable iff (!RST_N_I)
    take && REQ_I.write && REQ_I.word && LANE_ORDER_STRAP_I && REQ_I.addr == HBL_FIRMWARE_REVISION_OFS
    |=> firmware_revision_register == $past(REQ_I.wdata[7:0])) else $error("low lane not first byte");
  map_swap_a: assert property (@(posedge CLOCK_I) disable iff (!RST_N_I)
    take && REQ_I.write && !REQ_I.word && !LANE_ORDER_STRAP_I && REQ_I.addr == 8'h81
    |=> firmware_revision_register == $past(REQ_I.wdata[7:0])) else $error("map not selected by strap");
  global_any_chan_a: assert property (@(posedge CLOCK_I) disable iff (!RST_N_I)
    take && !REQ_I.write && !REQ_I.word && LANE_ORDER_STRAP_I && REQ_I.addr == HBL_FIRMWARE_REVISION_OFS
    |=> DATA_O[7:0] == firmware_revision_register) else $error("global read depends on channel");

  word_read_c: cover property (@(posedge CLOCK_I) take && REQ_I.word && !REQ_I.write);
  ctx_access_c: cover property (@(posedge CLOCK_I) take && CTX_I.valid && is_per[0]);
  sync_dual_c: cover property (@(posedge CLOCK_I) take && is_dual[0]);

  // Helpers for read-path checks (lane 0 only; lane 1 mirrors it)
  logic [7:0] per_rd0;
  logic [7:0] sync_rd0;
  logic rd_take;
  logic wr_take;
  assign per_rd0 = bank[active_chan][canon[0]];
  assign sync_rd0 = sync_bank[active_chan][canon[0][1:0]];
  assign rd_take = take && !REQ_I.write;
  assign wr_take = take && REQ_I.write;

  // ------------------------------------------------------------
  // Further checks: handshake shape and read routing
  // ------------------------------------------------------------
  // Ack must never appear without a request taken first
  ack_needs_take_a: assert property (@(posedge CLOCK_I) disable iff (!RST_N_I)
    !take && !ACK_O |=> !ACK_O) else $error("ack without request");
  // Bus drive only on reads, so a write never fights the host
  read_oe_a: assert property (@(posedge CLOCK_I) disable iff (!RST_N_I)
    rd_take |=> DATA_OE_O) else $error("data not driven on read");
  write_oe_a: assert property (@(posedge CLOCK_I) disable iff (!RST_N_I)
    wr_take |=> !DATA_OE_O) else $error("data driven on write");
  // Read data must stand untouched between reads
  data_hold_a: assert property (@(posedge CLOCK_I) disable iff (!RST_N_I)
    !rd_take |=> $stable(DATA_O)) else $error("read data changed between reads");
  // A byte bound for the high lane leaves the low lane empty
  lane_high_a: assert property (@(posedge CLOCK_I) disable iff (!RST_N_I)
    rd_take && !REQ_I.word && (REQ_I.addr[0] == LANE_ORDER_STRAP_I)
    |=> DATA_O[7:0] == 8'h00) else $error("byte on wrong lane");
  // Per-channel read comes from the active bank only
  per_read_a: assert property (@(posedge CLOCK_I) disable iff (!RST_N_I)
    rd_take && lane_en[0] && is_per[0] && !is_dual[0] && !is_fw[0] && !is_cs[0]
    |=> DATA_O[7:0] == $past(per_rd0)) else $error("per-channel read from wrong bank");
  // In sync mode the dual-use offsets read the separate store
  sync_read_a: assert property (@(posedge CLOCK_I) disable iff (!RST_N_I)
    rd_take && lane_en[0] && is_dual[0] && !is_fw[0] && !is_cs[0]
    |=> DATA_O[7:0] == $past(sync_rd0)) else $error("sync register read wrong");

  // Scenario covers
  strap_low_read_c: cover property (@(posedge CLOCK_I) rd_take && !LANE_ORDER_STRAP_I);
  chan_write_c: cover property (@(posedge CLOCK_I) cs_wr);

endmodule
`default_nettype wire

/* File: dv/hbl_host.sv */
/*
  Host bus model: one request per chip select, held until acknowledge.
  Assumes a single clock; calls start at a rising edge.
*/
`timescale 1ns/1ps
`default_nettype none
module hbl_host (
  input wire logic clk_i,            // Bus clock
  input wire logic ack_i,            // Device acknowledge
  input wire logic [15:0] data_i,    // Device read data
  output logic cs_n_o,               // Chip select, active low
  output hbl_pkg::hbl_req_type req_o // Held request
);
  import hbl_pkg::*;
  logic to_flag; // Acknowledge never came
  int lat; // Edges from take to acknowledge
  initial begin
    cs_n_o = 1'b1;
    req_o = '0;
    to_flag = 1'b0;
    lat = 0;
  end
  // ----------
  // Bus cycle
  // ----------
  // Address, width and direction set by caller; task drives select
  task automatic xfer(input logic [7:0] a, input logic w, input logic wr, input logic [15:0] d,
                      output logic [15:0] q);
    int n;
    n = 0;
    cs_n_o <= 1'b0;
    req_o <= '{addr: a, word: w, write: wr, wdata: d};
    @(posedge clk_i);
    do begin
      @(posedge clk_i);
      n++;
    end while (ack_i !== 1'b1 && n < 20);
    to_flag = (ack_i !== 1'b1);
    lat = n;
    q = data_i;
    cs_n_o <= 1'b1;
    req_o <= ~req_o; // Released bus shows no stale value
    @(posedge clk_i);
  endtask
endmodule
`default_nettype wire

/* File: dv/tb.sv */
/*
  Testbench: register traffic through the host model in both strap settings.
  Assumes the strap stays static between resets.
*/
`timescale 1ns/1ps
`default_nettype none
module tb;
  import hbl_pkg::*;
  logic clk = 1'b0;
  logic rst_n, strap, cs_n, ack, oe;
  hbl_req_type req;
  hbl_ctx_type ctx;
  logic [15:0] dout;
  int n_fail = 0;
  int n_compared = 0;
  logic oe_ack = 1'b0; // Drive enable seen while acknowledged
  always @(posedge clk) begin
    if (ack) begin
      oe_ack <= oe;
    end
  end
  always #25 clk = ~clk;
  hbl_bank hbl_bank_inst (.CLOCK_I(clk), .RST_N_I(rst_n), .LANE_ORDER_STRAP_I(strap), .CS_N_I(cs_n),
    .REQ_I(req), .CTX_I(ctx), .DATA_O(dout), .DATA_OE_O(oe), .ACK_O(ack));
  hbl_host hbl_host_inst (.clk_i(clk), .ack_i(ack), .data_i(dout), .cs_n_o(cs_n), .req_o(req));
  // ----------
  // Tasks
  // ----------
  task automatic end_sim();
    $display("Compared %0d, failed %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
    n_compared++;
    if (seen !== exp) begin
      n_fail++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic acc(input logic [7:0] a, input logic w, input logic wr, input logic [15:0] d,
                     output logic [15:0] q);
    hbl_host_inst.xfer(a, w, wr, d, q);
    chk("ack_timeout", 16'(hbl_host_inst.to_flag), 16'h0000);
    if (hbl_host_inst.to_flag) begin
      end_sim();
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic w, input logic [15:0] d);
    logic [15:0] q;
    acc(a, w, 1'b1, d, q);
    chk("oe_write", 16'(oe_ack), 16'h0000);
  endtask
  task automatic rd(input string nm, input logic [7:0] a, input logic [15:0] e);
    logic [15:0] q;
    acc(a, 1'b0, 1'b0, 16'h0000, q);
    chk(nm, q, e);
    chk("oe_read", 16'(oe_ack), 16'h0001);
  endtask
  task automatic reset_to(input logic s);
    rst_n <= 1'b0;
    strap <= s;
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
  endtask
  // Main sequence
  initial begin
    rst_n = 1'b0;
    strap = 1'b1;
    ctx = '0;
    @(posedge clk);
    reset_to(1'b1);
    wr(8'hEC, 1'b0, 16'h0002);
    rd("chan_sel", 8'hEC, 16'h0002);
    chk("latency", 16'(hbl_host_inst.lat), 16'h0001);
    wr(8'h82, 1'b0, 16'h005A);
    rd("fw_rev", 8'h82, 16'h005A);
    for (int c = 0; c < 4; c++) begin
      wr(8'hEC, 1'b0, 16'(c));
      wr(8'h10, 1'b0, 16'(c) + 16'h0030);
    end
    for (int c = 0; c < 4; c++) begin
      wr(8'hEC, 1'b0, 16'(c));
      rd("bank", 8'h10, 16'(c) + 16'h0030);
    end
    wr(8'h10, 1'b1, 16'hBBAA);
    rd("word_hi", 8'h11, 16'hBB00);
    ctx <= '{valid: 1'b1, chan: 2'd1};
    rd("ctx_bank", 8'h10, 16'h0031);
    ctx <= '0;
    rd("sel_kept", 8'hEC, 16'h0003);
    wr(8'hEC, 1'b0, 16'h0000);
    wr(8'h18, 1'b0, 16'h0000);
    wr(8'h1C, 1'b0, 16'h0011);
    wr(8'h18, 1'b0, 16'h0080);
    wr(8'h1C, 1'b0, 16'h0022);
    rd("sync_reg", 8'h1C, 16'h0022);
    wr(8'h18, 1'b0, 16'h0000);
    rd("async_reg", 8'h1C, 16'h0011);
    $display("test linear map done");
    reset_to(1'b0);
    rd("sel_rst", 8'hEE, 16'h0000);
    wr(8'hEE, 1'b0, 16'h0100);
    rd("sel_alt", 8'hEE, 16'h0100);
    chk("latency", 16'(hbl_host_inst.lat), 16'h0001);
    wr(8'h81, 1'b0, 16'h0077);
    rd("fw_alt", 8'h81, 16'h0077);
    wr(8'h10, 1'b1, 16'hBBAA);
    rd("word_even", 8'h10, 16'hBB00);
    rd("word_odd", 8'h11, 16'h00AA);
    $display("test alternate map done");
    end_sim();
  end
endmodule
`default_nettype wire
